// *** pkg/sar_consts.svh ***
// Constants for the converter control block: field positions, reset values and timing counts.
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Control byte field positions
// ----------------------------------------------------------------------------
`define SAR_CTRL_W            8
`define SAR_BIT_PWR_HI        7
`define SAR_BIT_PWR_LO        6
`define SAR_BIT_ACQ_SEL       5
`define SAR_BIT_SINGLE        4
`define SAR_BIT_POLARITY      3
`define SAR_CHAN_HI           2
`define SAR_CHAN_LO           0
`define SAR_CTRL_RST          8'hC0

// ----------------------------------------------------------------------------
// Result layout
// ----------------------------------------------------------------------------
`define SAR_RES_W             10
`define SAR_RES_MSB           9
`define SAR_RES_HI_LSB        8
`define SAR_HI_FILL_W         6
`define SAR_TRIAL_FIRST       10'h200
`define SAR_RES_RST           10'h000

// ----------------------------------------------------------------------------
// Pin synchroniser layout: {data[7:0], conv_clk, high_byte_select, rd_n, wr_n, cs_n}
// ----------------------------------------------------------------------------
`define SAR_SYNC_W            13
`define SAR_SYNC_RST          13'h0007
`define SAR_SYNC_CS           0
`define SAR_SYNC_WR           1
`define SAR_SYNC_RD           2
`define SAR_SYNC_HB           3
`define SAR_SYNC_CLK          4
`define SAR_SYNC_DATA_LO      5
`define SAR_SYNC_DATA_HI      12

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SAR_SYS_PERIOD_PS     5000
`define SAR_INT_ACQ_NS        1000
`define SAR_INT_CONV_NS       3600
`define SAR_CONV_TICKS        13
`define SAR_EXT_ACQ_EDGES     4
`define SAR_INT_ACQ_CYC       ((`SAR_INT_ACQ_NS * 1000) / `SAR_SYS_PERIOD_PS)
`define SAR_INT_TICK_CYC      ((`SAR_INT_CONV_NS * 1000) / (`SAR_CONV_TICKS * `SAR_SYS_PERIOD_PS))
`define SAR_DIV_W             8
`define SAR_TICK_W            4

`endif

// *** pkg/sar_pkg.sv ***
// Types shared by the converter control block.
package sar_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE      = 2'b00,
		ST_ACQ_TIMED = 2'b01,
		ST_ACQ_HELD  = 2'b10,
		ST_CONVERT   = 2'b11
	} seq_state_t;

	typedef enum logic [1:0]
	{
		PWR_NORMAL   = 2'b00,
		PWR_STANDBY  = 2'b01,
		PWR_SHUTDOWN = 2'b10
	} power_state_t;

	typedef struct packed
	{
		seq_state_t   state;
		logic [7:0]   ctrl;
		logic         clk_ext;
		power_state_t power;
		logic [7:0]   div;
		logic [3:0]   tick;
		logic [9:0]   trial;
		logic [9:0]   mask;
		logic [9:0]   result;
		logic         result_uni;
		logic         done_n;
		logic [7:0]   dout;
		logic         wr_prev;
		logic         rd_prev;
		logic         clk_prev;
	} ctl_state_t;

	typedef struct packed
	{
		logic [12:0] s1;
		logic [12:0] s2;
		logic [12:0] s3;
		logic [12:0] out;
	} sync_state_t;

endpackage

// *** rtl/sar_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`include "sar_consts.svh"

module sar_pin_sync
(
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	// Pins and their filtered copies
	input  wire logic [`SAR_SYNC_W-1:0]   pins_in,
	output logic      [`SAR_SYNC_W-1:0]   pins_out
);

	sar_pkg::sync_state_t q;
	sar_pkg::sync_state_t d;
	logic [`SAR_SYNC_W-1:0] agree;

	// ------------------------------------------------------------------------
	// Per-bit agreement of the second and third stage
	// ------------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `SAR_SYNC_W; i = i + 1)
		begin : g_agree
			assign agree[i] = ~(q.s2[i] ^ q.s3[i]);
		end
	endgenerate

	always_comb
	begin
		d     = q;
		d.s1  = pins_in;
		d.s2  = q.s1;
		d.s3  = q.s2;
		d.out = (agree & q.s3) | (~agree & q.out);
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			q <= {4{`SAR_SYNC_RST}};
		end
		else
		begin
			q <= d;
		end
	end

	assign pins_out = q.out;

endmodule

// *** rtl/sar_adc_parallel_control.sv ***
// Control, sequencing and byte-wide host port of a 10-bit successive-approximation converter.
//
// What this block does
// RULE_01 - Internal acquisition timed, then conversion starts
// RULE_02 - External acquisition lasts until next byte
// RULE_03 - Second byte ends acquisition, starts conversion
// RULE_04 - Host repeats channel address on second byte
// RULE_05 - Host changes only power bits second time
// RULE_06 - Done flag low when result ready
// RULE_07 - Done flag high on read or write
// RULE_08 - Power bits select down, standby, clock mode
// RULE_09 - Power-down bytes keep previous clock mode
// RULE_10 - Reset selects external clock mode
// RULE_11 - Bit 5 selects acquisition mode
// RULE_12 - Bit 4 selects single-ended or pair
// RULE_13 - Bit 3 selects unipolar or bipolar
// RULE_14 - Low three bits address the channel
// RULE_15 - Internal clock makes conversion last 3.6us
// RULE_16 - Host supplies external clock in range
// RULE_17 - Chip select high ignores inputs, bus released
// RULE_18 - Control byte latched from all lines
// RULE_19 - Result straight binary or two's complement
// RULE_20 - Low byte read with select at zero
// RULE_21 - High byte read zero or sign filled
// RULE_22 - Conversion always lasts thirteen clock ticks; a write during conversion ends it sooner
// RULE_23 - Write during conversion aborts, reacquires
// RULE_24 - Hold on fourth falling clock edge
// RULE_25 - Write rising edge wakes from standby
// RULE_26 - Result latch holds last completed sample
`timescale 1ns/1ps
`include "sar_consts.svh"

module sar_adc_parallel_control
(
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     reset,
	// Host port pins
	input  wire logic                     cs_n,
	input  wire logic                     wr_n,
	input  wire logic                     rd_n,
	input  wire logic                     high_byte_select,
	input  wire logic                     conv_clk,
	input  wire logic [7:0]               data_in,
	output logic      [7:0]               data_out,
	output logic                          data_oe,
	output logic                          done_n,
	// Converter core
	input  wire logic                     cmp_ge,
	output logic      [9:0]               sar_trial,
	output logic                          sample_track,
	output logic                          conv_active,
	output logic      [2:0]               channel_addr,
	output logic                          single_ended,
	output logic                          unipolar,
	output logic                          ext_clock_mode,
	output sar_pkg::power_state_t         power_state
);

	localparam logic [7:0] INT_ACQ_LAST  = 8'(`SAR_INT_ACQ_CYC - 1);
	localparam logic [7:0] INT_TICK_LAST = 8'(`SAR_INT_TICK_CYC - 1);
	localparam logic [3:0] EXT_ACQ_LAST  = 4'(`SAR_EXT_ACQ_EDGES - 1);
	localparam logic [3:0] CONV_LAST     = 4'(`SAR_CONV_TICKS - 1);

	sar_pkg::ctl_state_t q;
	sar_pkg::ctl_state_t d;

	logic [`SAR_SYNC_W-1:0] pins_raw;
	logic [`SAR_SYNC_W-1:0] pins_s;
	logic                   cs_s;
	logic                   wr_s;
	logic                   rd_s;
	logic                   hb_s;
	logic                   clk_s;
	logic [7:0]             din_s;
	logic                   write_evt;
	logic                   read_evt;
	logic                   clk_fall;
	logic                   conv_tick;
	logic [9:0]             kept;
	logic [9:0]             mask_next;

	// ------------------------------------------------------------------------
	// Power mode decode
	// ------------------------------------------------------------------------
	// Both power-down codes have the high power bit clear.
	function automatic logic is_power_down(input logic [7:0] ctrl);
		is_power_down = ~ctrl[`SAR_BIT_PWR_HI];
	endfunction

	function automatic sar_pkg::power_state_t rest_state(input logic [7:0] ctrl);
		if (!is_power_down(ctrl))
		begin
			rest_state = sar_pkg::PWR_NORMAL;
		end
		else if (ctrl[`SAR_BIT_PWR_LO])
		begin
			rest_state = sar_pkg::PWR_STANDBY;
		end
		else
		begin
			rest_state = sar_pkg::PWR_SHUTDOWN;
		end
	endfunction

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// The data lines pass the same delay as the write strobe, so the byte seen at the
	// synchronised rising edge is the one the host held around its own edge.
	assign pins_raw = {data_in, conv_clk, high_byte_select, rd_n, wr_n, cs_n};

	sar_pin_sync u_sync
	(
		.sys_clk  (sys_clk),
		.reset    (reset),
		.pins_in  (pins_raw),
		.pins_out (pins_s)
	);

	assign cs_s  = pins_s[`SAR_SYNC_CS];
	assign wr_s  = pins_s[`SAR_SYNC_WR];
	assign rd_s  = pins_s[`SAR_SYNC_RD];
	assign hb_s  = pins_s[`SAR_SYNC_HB];
	assign clk_s = pins_s[`SAR_SYNC_CLK];
	assign din_s = pins_s[`SAR_SYNC_DATA_HI:`SAR_SYNC_DATA_LO];

	// ------------------------------------------------------------------------
	// Strobe events, all gated by chip select
	// ------------------------------------------------------------------------
	assign write_evt = ~cs_s & wr_s & ~q.wr_prev; // RULE_17
	assign read_evt  = ~cs_s & ~rd_s & q.rd_prev; // RULE_17
	assign clk_fall  = ~cs_s & ~clk_s & q.clk_prev; // RULE_17

	// One conversion clock tick: a falling pin edge, or the end of an internal divider period.
	assign conv_tick = q.clk_ext ? clk_fall : (q.div == INT_TICK_LAST); // RULE_15

	// One successive-approximation step on the bit under test.
	assign kept      = cmp_ge ? q.trial : (q.trial & ~q.mask);
	assign mask_next = q.mask >> 1;

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	always_comb
	begin
		d          = q;
		d.wr_prev  = wr_s;
		d.rd_prev  = rd_s;
		d.clk_prev = clk_s;

		if (read_evt)
		begin
			d.done_n = 1'b1; // RULE_07
		end

		if (write_evt)
		begin
			d.ctrl   = din_s; // RULE_18
			d.done_n = 1'b1; // RULE_07
			d.power  = sar_pkg::PWR_NORMAL; // RULE_25
			d.div    = 8'h00;
			d.tick   = 4'h0;
			if (!is_power_down(din_s))
			begin
				d.clk_ext = din_s[`SAR_BIT_PWR_LO]; // RULE_08 RULE_09
			end
			if (din_s[`SAR_BIT_ACQ_SEL])
			begin
				d.state = sar_pkg::ST_ACQ_HELD; // RULE_02 RULE_11
			end
			else if (q.state == sar_pkg::ST_ACQ_HELD)
			begin
				// The host keeps address and mode bits unchanged on this byte.
				d.state = sar_pkg::ST_CONVERT; // RULE_03 RULE_04 RULE_05
				d.trial = `SAR_TRIAL_FIRST;
				d.mask  = `SAR_TRIAL_FIRST;
			end
			else
			begin
				// Also the abort path when a byte lands mid-conversion.
				d.state = sar_pkg::ST_ACQ_TIMED; // RULE_01 RULE_23
			end
		end
		else
		begin
			unique case (q.state)
				sar_pkg::ST_IDLE:
				begin
					d.div = 8'h00;
				end
				sar_pkg::ST_ACQ_HELD:
				begin
					d.div = 8'h00;
				end
				sar_pkg::ST_ACQ_TIMED:
				begin
					d.div = q.div + 8'h01;
					if (q.clk_ext ? (clk_fall && q.tick == EXT_ACQ_LAST) : (q.div == INT_ACQ_LAST)) // RULE_01 RULE_24
					begin
						d.state = sar_pkg::ST_CONVERT;
						d.div   = 8'h00;
						d.tick  = 4'h0;
						d.trial = `SAR_TRIAL_FIRST;
						d.mask  = `SAR_TRIAL_FIRST;
					end
					else if (q.clk_ext && clk_fall)
					begin
						d.tick = q.tick + 4'h1;
					end
				end
				sar_pkg::ST_CONVERT:
				begin
					d.div = q.div + 8'h01;
					if (conv_tick)
					begin
						d.div  = 8'h00;
						d.tick = q.tick + 4'h1;
						if (q.mask != 10'h000)
						begin
							d.trial = kept | mask_next;
							d.mask  = mask_next;
						end
						if (q.tick == CONV_LAST) // RULE_22
						begin
							// Completion is evaluated after the read clear, so it wins.
							d.state      = sar_pkg::ST_IDLE;
							d.result     = {kept[`SAR_RES_MSB] ^ ~q.ctrl[`SAR_BIT_POLARITY],
								kept[`SAR_RES_MSB-1:0]}; // RULE_13 RULE_19 RULE_26
							d.result_uni = q.ctrl[`SAR_BIT_POLARITY];
							d.done_n     = 1'b0; // RULE_06
							d.power      = rest_state(q.ctrl); // RULE_08
						end
					end
				end
			endcase
		end

		// Output byte is refreshed every cycle from the result latch.
		if (hb_s)
		begin
			d.dout = {(q.result_uni ? {`SAR_HI_FILL_W{1'b0}} : {`SAR_HI_FILL_W{q.result[`SAR_RES_MSB]}}),
				q.result[`SAR_RES_MSB:`SAR_RES_HI_LSB]}; // RULE_21
		end
		else
		begin
			d.dout = q.result[7:0]; // RULE_20
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			q            <= '0;
			q.state      <= sar_pkg::ST_IDLE;
			q.ctrl       <= `SAR_CTRL_RST;
			q.clk_ext    <= 1'b1; // RULE_10
			q.power      <= sar_pkg::PWR_NORMAL;
			q.result     <= `SAR_RES_RST;
			q.result_uni <= 1'b1;
			q.done_n     <= 1'b1;
			q.wr_prev    <= 1'b1;
			q.rd_prev    <= 1'b1;
			q.clk_prev   <= 1'b0;
		end
		else
		begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign data_out       = q.dout;
	assign data_oe        = ~cs_s & ~rd_s; // RULE_17 RULE_20
	assign done_n         = q.done_n;
	assign sar_trial      = q.trial;
	assign sample_track   = (q.state == sar_pkg::ST_ACQ_TIMED) | (q.state == sar_pkg::ST_ACQ_HELD); // RULE_24
	assign conv_active    = (q.state == sar_pkg::ST_CONVERT);
	assign channel_addr   = q.ctrl[`SAR_CHAN_HI:`SAR_CHAN_LO]; // RULE_14
	assign single_ended   = q.ctrl[`SAR_BIT_SINGLE]; // RULE_12
	assign unipolar       = q.ctrl[`SAR_BIT_POLARITY]; // RULE_13
	assign ext_clock_mode = q.clk_ext;
	assign power_state    = q.power;

endmodule

// *** tb/sar_adc_parallel_control_sva.sv ***
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module sar_adc_parallel_control_sva
(
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  reset,
	// Host port
	input wire logic                  cs_n,
	input wire logic                  data_oe,
	input wire logic                  done_n,
	// Converter core
	input wire logic [9:0]            sar_trial,
	input wire logic                  sample_track,
	input wire logic                  conv_active,
	input wire logic                  ext_clock_mode,
	input wire sar_pkg::power_state_t power_state
);
	logic [9:0] conv_cnt_q;
	logic [9:0] conv_cnt_d;

	// Counts conversion cycles so the internal-clock length can be bounded.
	always_comb
	begin
		conv_cnt_d = conv_active ? conv_cnt_q + 10'h001 : 10'h000;
	end

	always_ff @(posedge sys_clk)
	begin
		conv_cnt_q <= reset ? 10'h000 : conv_cnt_d;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_conv_begin;
		$rose(conv_active);
	endsequence

	sequence s_conv_end;
		$fell(conv_active) ##0 !done_n;
	endsequence

	a_bus_released: assert property (cs_n [*5] |-> !data_oe) else $error("bus driven while deselected");
	a_read_clears: assert property ($rose(data_oe) && !conv_active |=> done_n) else $error("done kept over read");
	a_write_clears: assert property ($rose(sample_track) |-> done_n) else $error("done kept over write");
	a_done_source: assert property ($fell(done_n) |-> $past(conv_active)) else $error("done without conversion");
	a_conv_after_acq: assert property (s_conv_begin |-> $past(sample_track)) else $error("conversion without acquisition");
	a_first_trial: assert property (s_conv_begin |-> sar_trial == 10'h200) else $error("first trial code wrong");
	a_int_conv_len: assert property
		(s_conv_end ##0 !ext_clock_mode |-> conv_cnt_q inside {[10'h2CA:10'h2CC]})
		else $error("internal conversion length wrong");
	a_wake_normal: assert property ($rose(sample_track) |-> power_state == sar_pkg::PWR_NORMAL)
		else $error("write did not wake");
	a_mode_kept: assert property ($changed(ext_clock_mode) |-> power_state == sar_pkg::PWR_NORMAL)
		else $error("clock mode changed in power-down");
	a_done_cleared: assert property ($rose(done_n) |-> $past(data_oe) || sample_track)
		else $error("done cleared without read or write");
endmodule

bind sar_adc_parallel_control sar_adc_parallel_control_sva i_sva
(
	.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .data_oe(data_oe), .done_n(done_n), .sar_trial(sar_trial),
	.sample_track(sample_track), .conv_active(conv_active), .ext_clock_mode(ext_clock_mode),
	.power_state(power_state)
);

// *** tb/host_bus_model.sv ***
// Host processor model driving the converter's byte-wide port and conversion clock.
`timescale 1ns/1ps
module host_bus_model
(
	// Clock
	input wire logic        sys_clk,
	// Device port
	input wire logic [7:0]  data_out,
	input wire logic        data_oe,
	output logic            cs_n,
	output logic            wr_n,
	output logic            rd_n,
	output logic            high_byte_select,
	output logic            conv_clk,
	output logic [7:0]      data_in
);
	initial
	begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		high_byte_select = 1'b0;
		conv_clk = 1'b0;
		data_in = 8'h00;
	end

	task automatic write_byte(input logic [7:0] b, input logic cs);
		@(negedge sys_clk);
		cs_n = cs;
		data_in = b;
		wr_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		wr_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		// Released lines show a changing pattern so a stale byte cannot pass.
		data_in = ~b;
	endtask

	task automatic read_byte(input logic hb, input logic cs, output logic [7:0] q, output logic oe);
		@(negedge sys_clk);
		cs_n = cs;
		high_byte_select = hb;
		rd_n = 1'b0;
		data_in = ~data_in;
		repeat (8) @(negedge sys_clk);
		q = data_out;
		oe = data_oe;
		rd_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		cs_n = 1'b0;
	endtask

	// Clock stands low between frames; 42 cycles gives about 4.76 MHz.
	task automatic clk_falls(input int n);
		repeat (n)
		begin
			conv_clk = 1'b1;
			repeat (21) @(negedge sys_clk);
			conv_clk = 1'b0;
			repeat (21) @(negedge sys_clk);
		end
	endtask
endmodule

// *** tb/sar_adc_parallel_control_tb_top.sv ***
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module sar_adc_parallel_control_tb_top;
	logic sys_clk, reset, cs_n, wr_n, rd_n, high_byte_select, conv_clk, data_oe, done_n, cmp_ge;
	logic sample_track, conv_active, single_ended, unipolar, ext_clock_mode, oe;
	logic [7:0] data_in, data_out, got;
	logic [9:0] sar_trial, ain;
	logic [2:0] channel_addr;
	logic [4:0] f;
	sar_pkg::power_state_t power_state;
	int n_fail, checked, n, exp_q[$];

	assign cmp_ge = (ain >= sar_trial);

	sar_adc_parallel_control i_sar_adc_parallel_control
	(
		.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.high_byte_select(high_byte_select), .conv_clk(conv_clk), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .done_n(done_n), .cmp_ge(cmp_ge), .sar_trial(sar_trial), .sample_track(sample_track),
		.conv_active(conv_active), .channel_addr(channel_addr), .single_ended(single_ended), .unipolar(unipolar),
		.ext_clock_mode(ext_clock_mode), .power_state(power_state)
	);

	host_bus_model i_host_bus_model
	(
		.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.high_byte_select(high_byte_select), .conv_clk(conv_clk), .data_in(data_in)
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic push_exp(input int a, input logic uni);
		int r;
		r = uni ? a : a ^ 512;
		exp_q.push_back(r & 255);
		exp_q.push_back((r >> 8) | (uni ? 0 : (r >> 9) * 252));
	endtask

	task automatic read_pair;
		int lo;
		lo = exp_q.pop_front();
		i_host_bus_model.read_byte(1'b0, 1'b0, got, oe);
		chk(got, lo);
		chk(oe, 1);
		i_host_bus_model.read_byte(1'b1, 1'b0, got, oe);
		chk(got, exp_q.pop_front());
		chk(done_n, 1);
		i_host_bus_model.read_byte(1'b0, 1'b0, got, oe);
		chk(got, lo);
	endtask

	task automatic finish_conv;
		n = 0;
		if (ext_clock_mode === 1'b1)
			i_host_bus_model.clk_falls(17);
		while (done_n !== 1'b0 && n < 3000)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk(done_n, 0);
		read_pair;
	endtask

	task automatic conv(input logic [7:0] cb);
		ain = 10'($urandom);
		push_exp(ain, cb[3]);
		i_host_bus_model.write_byte(cb, 1'b0);
		chk(power_state, sar_pkg::PWR_NORMAL);
		finish_conv;
	endtask

	initial
	begin
		void'($urandom(93761));
		reset = 1'b1;
		ain = 10'h000;
		repeat (12) @(negedge sys_clk);
		reset = 1'b0;
		chk(ext_clock_mode, 1);
		chk(done_n, 1);
		$display("test reset done");
		for (int i = 0; i < 2; i++)
		begin
			f = 5'($urandom);
			f[3] = i[0];
			ain = 10'($urandom);
			push_exp(ain, f[3]);
			i_host_bus_model.write_byte({3'b110, f}, 1'b0);
			chk(channel_addr, f[2:0]);
			chk(single_ended, f[4]);
			chk(unipolar, f[3]);
			chk(sample_track, 1);
			i_host_bus_model.clk_falls(3);
			chk(conv_active, 0);
			i_host_bus_model.clk_falls(1);
			chk(conv_active, 1);
			i_host_bus_model.clk_falls(12);
			chk(conv_active, 1);
			i_host_bus_model.clk_falls(1);
			chk(done_n, 0);
			read_pair;
		end
		$display("test external clock done");
		f = 5'($urandom);
		conv({3'b100, f});
		chk(ext_clock_mode, 0);
		chk(n >= 900 && n <= 930, 1);
		$display("test internal clock done");
		i_host_bus_model.write_byte({3'b101, f}, 1'b0);
		repeat (400) @(negedge sys_clk);
		chk(sample_track, 1);
		ain = 10'($urandom);
		push_exp(ain, f[3]);
		i_host_bus_model.write_byte({3'b100, f}, 1'b0);
		chk(conv_active, 1);
		finish_conv;
		$display("test external acquisition done");
		i_host_bus_model.write_byte({3'b100, f}, 1'b0);
		repeat (400) @(negedge sys_clk);
		chk(conv_active, 1);
		conv({3'b100, f});
		$display("test abort done");
		for (int pd = 0; pd < 2; pd++)
		begin
			conv({1'b0, pd[0], 1'b0, f});
			chk(power_state, pd ? sar_pkg::PWR_STANDBY : sar_pkg::PWR_SHUTDOWN);
			chk(ext_clock_mode, 0);
		end
		conv({3'b110, f});
		chk(ext_clock_mode, 1);
		$display("test power modes done");
		i_host_bus_model.write_byte({3'b100, ~f}, 1'b1);
		chk(channel_addr, f[2:0]);
		chk(sample_track, 0);
		i_host_bus_model.read_byte(1'b0, 1'b1, got, oe);
		chk(oe, 0);
		$display("test chip select done");
		i_host_bus_model.write_byte({3'b100, f}, 1'b0);
		repeat (1000) @(negedge sys_clk);
		chk(done_n, 0);
		i_host_bus_model.write_byte({3'b100, f}, 1'b0);
		chk(done_n, 1);
		$display("test write clear done");
		end_sim;
	end

	initial
	begin
		#200000;
		n_fail++;
		$display("watchdog expired at %0t", $time);
		end_sim;
	end
endmodule
